// ### common/sfr_irq_pkg.sv
// Constants for the special-function interrupt register bank.
// Assumes a byte-wide peripheral bus with an address of a few bits.
package sfr_irq_pkg;
  localparam int ADDR_W = 4;
  localparam logic [3:0] ENABLE_ONE_ADDR = 4'h0;
  localparam logic [3:0] ENABLE_TWO_ADDR = 4'h1;
  localparam logic [3:0] FLAG_ONE_ADDR = 4'h2;
  localparam logic [3:0] FLAG_TWO_ADDR = 4'h3;
  // Bit positions in the first enable byte
  localparam int WDT_IE_BIT = 0;
  localparam int OSC_IE_BIT = 1;
  localparam int NMI_IE_BIT = 4;
  localparam int ACCV_IE_BIT = 5;
  // Bit positions in the first flag byte
  localparam int WDT_IF_BIT = 0;
  localparam int OSC_IF_BIT = 1;
  localparam int POR_IF_BIT = 2;
  localparam int RST_IF_BIT = 3;
  localparam int NMI_IF_BIT = 4;
  // Reset values
  localparam logic [3:0] ENABLE_CLEAR_VAL = 4'h0;
  localparam logic OSC_FLAG_CLEAR_VAL = 1'b1;
  localparam logic NMI_FLAG_CLEAR_VAL = 1'b0;
  localparam logic POR_FLAG_POWER_VAL = 1'b1;
  localparam logic RST_FLAG_POWER_VAL = 1'b0;
  localparam logic WDT_FLAG_POWER_VAL = 1'b0;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
endpackage

// ### common/sfr_event_if.sv
// Carrier for event strobes between the bank and its flag module.
// Assumes all strobes are synchronous one-cycle pulses on core_clk.
`timescale 1ns/100ps
interface sfr_event_if;
  logic osc_fault_evt;
  logic nmi_evt;
  logic wdt_evt;
  logic reset_evt;
  logic wr_flag;
  logic [7:0] wr_data;
  logic clear_n;
  logic [4:0] flags;
  modport bank (output osc_fault_evt, nmi_evt, wdt_evt, reset_evt, wr_flag, wr_data, clear_n, input flags);
  modport flag (input osc_fault_evt, nmi_evt, wdt_evt, reset_evt, wr_flag, wr_data, clear_n, output flags);
endinterface

// ### design/sfr_flag_store.sv
// Storage for the first interrupt flag byte.
// Assumes rstn is power-on reset and clear_n the weaker power-up clear.
`timescale 1ns/100ps
module sfr_flag_store
(
  input wire logic core_clk,
  input wire logic rstn,
  sfr_event_if.flag ev
);
  import sfr_irq_pkg::*;
  logic [4:0] flags_reg;
  logic [4:0] flags_next;
  assign ev.flags = flags_reg;

  // Hardware set wins over a software write in the same cycle
  always_comb begin
    flags_next = flags_reg;
    if (ev.wr_flag) begin
      flags_next = ev.wr_data[4:0];
    end
    if (ev.wdt_evt) begin
      flags_next[WDT_IF_BIT] = 1'b1;
    end
    if (ev.osc_fault_evt) begin
      flags_next[OSC_IF_BIT] = 1'b1;
    end
    if (ev.reset_evt) begin
      flags_next[RST_IF_BIT] = 1'b1;
    end
    if (ev.nmi_evt) begin
      flags_next[NMI_IF_BIT] = 1'b1;
    end
    // Power-up clear touches only its own bits, the rest survive
    if (!ev.clear_n) begin
      flags_next[OSC_IF_BIT] = OSC_FLAG_CLEAR_VAL;
      flags_next[NMI_IF_BIT] = NMI_FLAG_CLEAR_VAL;
      flags_next[RST_IF_BIT] = flags_next[RST_IF_BIT] | ev.reset_evt;
    end
  end

  // Power-on reset initialises every flag
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      flags_reg[WDT_IF_BIT] <= WDT_FLAG_POWER_VAL;
      flags_reg[OSC_IF_BIT] <= OSC_FLAG_CLEAR_VAL;
      flags_reg[POR_IF_BIT] <= POR_FLAG_POWER_VAL;
      flags_reg[RST_IF_BIT] <= RST_FLAG_POWER_VAL;
      flags_reg[NMI_IF_BIT] <= NMI_FLAG_CLEAR_VAL;
    end else begin
      flags_reg <= flags_next;
    end
  end

  a_puc_sets_osc: assert property (@(posedge core_clk) disable iff (!rstn)
    !ev.clear_n |=> flags_reg[OSC_IF_BIT]) else $error("osc flag not set by clear");
  a_puc_keeps_por: assert property (@(posedge core_clk) disable iff (!rstn)
    (!ev.clear_n && !ev.wr_flag) |=> flags_reg[POR_IF_BIT] == $past(flags_reg[POR_IF_BIT]))
    else $error("por flag lost on clear");
  a_nmi_evt_sets: assert property (@(posedge core_clk) disable iff (!rstn)
    (ev.nmi_evt && ev.clear_n) |=> flags_reg[NMI_IF_BIT]) else $error("nmi flag not set");
  a_wdt_evt_sets: assert property (@(posedge core_clk) disable iff (!rstn)
    ev.wdt_evt |=> flags_reg[WDT_IF_BIT]) else $error("watchdog flag not set");
endmodule

// ### design/special_function_irq_regs.sv
// Special-function interrupt enable and flag bytes at addresses 0 to 3.
// Assumes a synchronous byte bus from the CPU and synchronous event strobes.
`timescale 1ns/100ps
// Function
// - Only bits with an assigned purpose are stored; all others read zero.
// - Enable bytes sit at address 0 and 1, flag bytes at 2 and 3.
// - Power-up-clear bits are read/write and forced on every clear and power-on reset.
// - Power-on bits are read/write, forced only by power-on reset, and survive a clear.
// - Enable byte one holds access violation, pin, oscillator and watchdog enables, cleared by clear.
// - Oscillator fault flag is set by a fault and set by every clear.
// - Power-on flag starts at one on power-on reset and is software clearable.
// - External reset flag is set by a pin reset, zero at power-up, and survives a clear.
// - Pin flag is set by a pin event and cleared by a clear.
// - Oscillator, pin and access violation requests ignore the global enable.
module special_function_irq_regs
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic power_up_clear_n,
  input wire logic [sfr_irq_pkg::ADDR_W-1:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  input wire logic osc_fault_event,
  input wire logic nmi_pin_event,
  input wire logic pin_reset_event,
  input wire logic watchdog_event,
  input wire logic watchdog_interval_mode,
  input wire logic flash_access_violation_flag,
  input wire logic global_irq_enable,
  output logic nonmaskable_irq_req,
  output logic watchdog_irq_req
);
  import sfr_irq_pkg::*;

  logic [3:0] enable_reg; // Only four enable bits exist
  logic [3:0] enable_next;
  logic [7:0] enable_byte;
  logic [7:0] flag_byte;
  sfr_event_if ev ();

  // Compact slots of the four stored enables, low to high
  localparam int WDT_SLOT = 0;
  localparam int OSC_SLOT = 1;
  localparam int PIN_SLOT = 2;
  localparam int ACCV_SLOT = 3;

  // Address decode helper used by write and read paths
  function automatic logic hit(input logic [3:0] a, input logic [3:0] target);
    hit = (a == target);
  endfunction

  // Strobe decode shared by the stores and the checks; the read path calls hit on its own
  logic enable_wr;
  logic flag_wr;
  logic enable_rd;
  logic flag_rd;
  logic absent_rd;
  assign enable_wr = bus_wr && hit(bus_addr, ENABLE_ONE_ADDR);
  assign flag_wr = bus_wr && hit(bus_addr, FLAG_ONE_ADDR);
  assign enable_rd = bus_rd && hit(bus_addr, ENABLE_ONE_ADDR);
  assign flag_rd = bus_rd && hit(bus_addr, FLAG_ONE_ADDR);
  assign absent_rd = bus_rd && !enable_rd && !flag_rd;

  // Per-source request terms, kept apart so each can be checked
  logic osc_req_term;
  logic pin_req_term;
  logic accv_req_term;
  logic wdt_req_term;

  assign ev.osc_fault_evt = osc_fault_event;
  assign ev.nmi_evt = nmi_pin_event;
  assign ev.wdt_evt = watchdog_event;
  assign ev.reset_evt = pin_reset_event;
  assign ev.wr_flag = flag_wr;
  assign ev.wr_data = bus_wdata;
  assign ev.clear_n = power_up_clear_n;

  sfr_flag_store flags_u (
    .core_clk(core_clk),
    .rstn(rstn),
    .ev(ev)
  );

  // Compact enable store: {access, pin, osc, watchdog}
  // Clear beats a write landing in the same cycle
  always_comb begin
    enable_next = enable_reg;
    if (enable_wr) begin
      enable_next = {bus_wdata[ACCV_IE_BIT], bus_wdata[NMI_IE_BIT], bus_wdata[OSC_IE_BIT],
                     bus_wdata[WDT_IE_BIT]};
    end
    if (!power_up_clear_n) begin
      enable_next = ENABLE_CLEAR_VAL;
    end
  end

  // Power-on reset here; the clear is folded into the next value
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      enable_reg <= ENABLE_CLEAR_VAL;
    end else begin
      enable_reg <= enable_next;
    end
  end

  // Absent bits read as zero since nothing stores them
  always_comb begin
    enable_byte = ZERO_BYTE;
    enable_byte[WDT_IE_BIT] = enable_reg[WDT_SLOT];
    enable_byte[OSC_IE_BIT] = enable_reg[OSC_SLOT];
    enable_byte[NMI_IE_BIT] = enable_reg[PIN_SLOT];
    enable_byte[ACCV_IE_BIT] = enable_reg[ACCV_SLOT];
    flag_byte = ZERO_BYTE;
    flag_byte[4:0] = ev.flags;
  end

  // Registered read data; unmapped and second bytes answer zero
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      bus_rdata <= ZERO_BYTE;
    end else if (bus_rd) begin
      if (hit(bus_addr, ENABLE_ONE_ADDR)) begin
        bus_rdata <= enable_byte;
      end else if (hit(bus_addr, FLAG_ONE_ADDR)) begin
        bus_rdata <= flag_byte;
      end else begin
        bus_rdata <= ZERO_BYTE;
      end
    end
  end

  // Global enable deliberately absent from the nonmaskable term
  always_comb begin
    osc_req_term = enable_reg[OSC_SLOT] && ev.flags[OSC_IF_BIT];
    pin_req_term = enable_reg[PIN_SLOT] && ev.flags[NMI_IF_BIT];
    accv_req_term = enable_reg[ACCV_SLOT] && flash_access_violation_flag;
    nonmaskable_irq_req = osc_req_term || pin_req_term || accv_req_term;
  end

  // Watchdog is maskable: interval mode and global enable both needed
  always_comb begin
    wdt_req_term = enable_reg[WDT_SLOT] && ev.flags[WDT_IF_BIT];
    watchdog_irq_req = wdt_req_term && watchdog_interval_mode && global_irq_enable;
  end

  a_nmi_no_gie: assert property (@(posedge core_clk) disable iff (!rstn)
    (enable_reg[1] && ev.flags[OSC_IF_BIT] && !global_irq_enable) |-> nonmaskable_irq_req)
    else $error("global enable blocked nonmaskable");
  a_wdt_mode_gate: assert property (@(posedge core_clk) disable iff (!rstn)
    !watchdog_interval_mode |-> !watchdog_irq_req) else $error("watchdog request outside interval mode");
  a_puc_clr_en: assert property (@(posedge core_clk) disable iff (!rstn)
    !power_up_clear_n |=> enable_reg == ENABLE_CLEAR_VAL) else $error("enables not cleared");
  a_read_enable: assert property (@(posedge core_clk) disable iff (!rstn)
    (bus_rd && hit(bus_addr, ENABLE_ONE_ADDR)) |=> bus_rdata == $past(enable_byte))
    else $error("enable readback wrong");
  a_reserved_zero: assert property (@(posedge core_clk) disable iff (!rstn)
    (bus_rd && (hit(bus_addr, ENABLE_TWO_ADDR) || hit(bus_addr, FLAG_TWO_ADDR))) |=> bus_rdata == ZERO_BYTE)
    else $error("absent byte not zero");

  // Writes land in the stored bits when nothing else acts
  a_enable_write: assert property (@(posedge core_clk) disable iff (!rstn)
    (enable_wr && power_up_clear_n) |=> (enable_byte[ACCV_IE_BIT] == $past(bus_wdata[ACCV_IE_BIT])) &&
      (enable_byte[NMI_IE_BIT] == $past(bus_wdata[NMI_IE_BIT])) &&
      (enable_byte[OSC_IE_BIT] == $past(bus_wdata[OSC_IE_BIT])) &&
      (enable_byte[WDT_IE_BIT] == $past(bus_wdata[WDT_IE_BIT])))
    else $error("enable write lost");
  a_flag_write: assert property (@(posedge core_clk) disable iff (!rstn)
    (flag_wr && power_up_clear_n && !osc_fault_event && !nmi_pin_event && !pin_reset_event && !watchdog_event)
      |=> ev.flags == $past(bus_wdata[NMI_IF_BIT:WDT_IF_BIT]))
    else $error("flag write lost");
  a_enable_hold: assert property (@(posedge core_clk) disable iff (!rstn)
    (!enable_wr && power_up_clear_n) |=> $stable(enable_reg))
    else $error("enables changed without write");

  // Hardware events set flags; the clear forces only its own bits
  a_osc_evt_sets: assert property (@(posedge core_clk) disable iff (!rstn)
    osc_fault_event |=> ev.flags[OSC_IF_BIT])
    else $error("osc flag not set by fault");
  a_rst_evt_sets: assert property (@(posedge core_clk) disable iff (!rstn)
    pin_reset_event |=> ev.flags[RST_IF_BIT])
    else $error("reset flag not set by pin");
  a_puc_clears_pin: assert property (@(posedge core_clk) disable iff (!rstn)
    !power_up_clear_n |=> !ev.flags[NMI_IF_BIT])
    else $error("pin flag not cleared by clear");
  a_puc_keeps_rst: assert property (@(posedge core_clk) disable iff (!rstn)
    (!power_up_clear_n && !flag_wr && !pin_reset_event) |=> ev.flags[RST_IF_BIT] == $past(ev.flags[RST_IF_BIT]))
    else $error("reset flag lost on clear");
  a_puc_keeps_wdt: assert property (@(posedge core_clk) disable iff (!rstn)
    (!power_up_clear_n && !flag_wr && !watchdog_event) |=> ev.flags[WDT_IF_BIT] == $past(ev.flags[WDT_IF_BIT]))
    else $error("watchdog flag lost on clear");

  // No flag rises without its event, a clear that sets it, or a write
  a_osc_stray_rise: assert property (@(posedge core_clk) disable iff (!rstn)
    (!flag_wr && !osc_fault_event && power_up_clear_n) |=> !$rose(ev.flags[OSC_IF_BIT]))
    else $error("osc flag rose without cause");
  a_por_stray_rise: assert property (@(posedge core_clk) disable iff (!rstn)
    !flag_wr |=> !$rose(ev.flags[POR_IF_BIT]))
    else $error("power-on flag rose without cause");
  a_rst_stray_rise: assert property (@(posedge core_clk) disable iff (!rstn)
    (!flag_wr && !pin_reset_event) |=> !$rose(ev.flags[RST_IF_BIT]))
    else $error("reset flag rose without cause");
  a_pin_stray_rise: assert property (@(posedge core_clk) disable iff (!rstn)
    (!flag_wr && !nmi_pin_event) |=> !$rose(ev.flags[NMI_IF_BIT]))
    else $error("pin flag rose without cause");
  a_wdt_stray_rise: assert property (@(posedge core_clk) disable iff (!rstn)
    (!flag_wr && !watchdog_event) |=> !$rose(ev.flags[WDT_IF_BIT]))
    else $error("watchdog flag rose without cause");

  // Read data: flag byte, absent bytes, and holding between reads
  a_read_flags: assert property (@(posedge core_clk) disable iff (!rstn)
    flag_rd |=> bus_rdata == $past(flag_byte))
    else $error("flag readback wrong");
  a_unmapped_zero: assert property (@(posedge core_clk) disable iff (!rstn)
    absent_rd |=> bus_rdata == ZERO_BYTE)
    else $error("unmapped byte not zero");
  a_rdata_holds: assert property (@(posedge core_clk) disable iff (!rstn)
    !bus_rd |=> $stable(bus_rdata))
    else $error("read data changed without read");

  // Requests follow flag and enable; global enable only for the watchdog
  a_wdt_req_source: assert property (@(posedge core_clk) disable iff (!rstn)
    watchdog_irq_req |-> (enable_reg[WDT_SLOT] && ev.flags[WDT_IF_BIT] && global_irq_enable))
    else $error("watchdog request without cause");
  a_nmi_req_masked: assert property (@(posedge core_clk) disable iff (!rstn)
    (!enable_reg[OSC_SLOT] && !enable_reg[PIN_SLOT] && !enable_reg[ACCV_SLOT]) |-> !nonmaskable_irq_req)
    else $error("nonmaskable request with all enables off");
  a_accv_no_gie: assert property (@(posedge core_clk) disable iff (!rstn)
    (enable_reg[ACCV_SLOT] && flash_access_violation_flag) |-> nonmaskable_irq_req)
    else $error("access violation request missing");
  a_pin_no_gie: assert property (@(posedge core_clk) disable iff (!rstn)
    (enable_reg[PIN_SLOT] && ev.flags[NMI_IF_BIT]) |-> nonmaskable_irq_req)
    else $error("pin request missing");
endmodule

// ### dv/cpu_bus_model.sv
// CPU-side model of the byte bus reaching the special-function bank.
// Assumes the bank samples strobes on the rising edge of core_clk.
`timescale 1ns/100ps
module cpu_bus_model (
  input wire logic core_clk,
  output logic [3:0] bus_addr,
  output logic bus_wr,
  output logic bus_rd,
  output logic [7:0] bus_wdata,
  input wire logic [7:0] bus_rdata
);
  // Idle bus at time zero
  initial begin
    bus_addr = 4'h0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_wdata = 8'h00;
  end
  // One-cycle write; data inverted afterwards so a stale byte is never reused
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk) #1;
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(posedge core_clk) #1;
    bus_wr = 1'b0;
    bus_wdata = ~d;
  endtask
  // Read data is registered, so it is taken one edge after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk) #1;
    bus_addr = a;
    bus_rd = 1'b1;
    @(posedge core_clk) #1;
    bus_rd = 1'b0;
    @(posedge core_clk);
    d = bus_rdata;
  endtask
endmodule

// ### dv/tb_top.sv
// Self-checking bench for the special-function interrupt register bank.
// Assumes the CPU bus model drives all bus traffic.
`timescale 1ns/100ps
module tb_top;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic pc_n = 1'b1;
  logic [3:0] evt = 4'h0;
  logic mode = 1'b1;
  logic accv = 1'b0;
  logic gie = 1'b0;
  logic [3:0] addr;
  logic wr, rd, nmi_req, wdt_req;
  logic [7:0] wdata, rdata;
  int n_errors = 0;
  int n_compared = 0;
  always #5 core_clk = ~core_clk;
  cpu_bus_model cpu (.core_clk(core_clk), .bus_addr(addr), .bus_wr(wr), .bus_rd(rd),
    .bus_wdata(wdata), .bus_rdata(rdata));
  special_function_irq_regs dut (.core_clk(core_clk), .rstn(rstn), .power_up_clear_n(pc_n),
    .bus_addr(addr), .bus_wr(wr), .bus_rd(rd), .bus_wdata(wdata), .bus_rdata(rdata),
    .osc_fault_event(evt[0]), .nmi_pin_event(evt[1]), .pin_reset_event(evt[2]),
    .watchdog_event(evt[3]), .watchdog_interval_mode(mode), .flash_access_violation_flag(accv),
    .global_irq_enable(gie), .nonmaskable_irq_req(nmi_req), .watchdog_irq_req(wdt_req));
  task automatic test_done;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_bit(input string n, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s exp %b got %b", n, e, g);
    end
  endtask
  // Bus read followed by a byte comparison
  task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] v;
    cpu.rd(a, v);
    chk_byte($sformatf("byte at %h", a), e, v);
  endtask
  // One-cycle event strobe: 0 osc, 1 pin nmi, 2 pin reset, 3 watchdog
  task automatic pulse(input int i);
    @(posedge core_clk) #1;
    evt[i] = 1'b1;
    @(posedge core_clk) #1;
    evt = 4'h0;
  endtask
  // Hang guard
  initial begin
    repeat (5000) @(posedge core_clk);
    n_errors++;
    test_done();
  end
  initial begin
    repeat (10) @(posedge core_clk);
    #1 rstn = 1'b1;
    rdchk(4'h0, 8'h00);
    rdchk(4'h2, 8'h06);
    // Unpresent bytes and bits hold nothing
    for (int a = 1; a < 16; a += 2) begin
      cpu.wr(4'(a), 8'hFF);
      rdchk(4'(a), 8'h00);
    end
    cpu.wr(4'h0, 8'hFF);
    rdchk(4'h0, 8'h33);
    cpu.wr(4'h2, 8'h00);
    rdchk(4'h2, 8'h00);
    chk_bit("nmi req idle", 1'b0, nmi_req);
    pulse(0);
    chk_bit("osc req", 1'b1, nmi_req);
    cpu.wr(4'h0, 8'h31);
    chk_bit("osc req masked", 1'b0, nmi_req);
    cpu.wr(4'h2, 8'h00);
    pulse(1);
    chk_bit("pin req", 1'b1, nmi_req);
    cpu.wr(4'h2, 8'h00);
    chk_bit("pin req cleared", 1'b0, nmi_req);
    accv = 1'b1;
    #1 chk_bit("accv req", 1'b1, nmi_req);
    @(posedge core_clk) #1 accv = 1'b0;
    pulse(3);
    chk_bit("wdt req no gie", 1'b0, wdt_req);
    gie = 1'b1;
    #1 chk_bit("wdt req", 1'b1, wdt_req);
    @(posedge core_clk) #1 mode = 1'b0;
    #1 chk_bit("wdt req reset mode", 1'b0, wdt_req);
    pulse(2);
    pulse(1);
    chk_bit("pin req with gie", 1'b1, nmi_req);
    rdchk(4'h2, 8'h19);
    // Power-up clear keeps power-on bits, forces the rest
    @(posedge core_clk) #1 pc_n = 1'b0;
    @(posedge core_clk) #1 pc_n = 1'b1;
    rdchk(4'h2, 8'h0B);
    rdchk(4'h0, 8'h00);
    chk_bit("req after clear", 1'b0, nmi_req);
    @(posedge core_clk) #1 rstn = 1'b0;
    @(posedge core_clk) #1 rstn = 1'b1;
    rdchk(4'h2, 8'h06);
    test_done();
  end
endmodule
